// ### design/wrs_top.sv
// Functional notes
// - Above turn-on: enable regulator, watchdog, alert circuitry
// - At or below turn-off: start shutdown
// - Charge output floats until first turn-on
// - Below turn-off: charge output driven low
// - Charge output frozen during deep sleep
// - Cycle straps sampled each wake pick period
// - Retransmit counter counts timer wakes, sends at zero
// - Retransmit straps pick interval or never
// - Alert wake sends a telegram only on a selected edge
// - Reload counter randomly after every transmission
// - Programmed settings override strap settings
// - Programmed settings load only after reset
// - Programmed wake period 1 to 65534 s
// - Min/max interval; equal disables randomness
// - Per-channel thresholds with defaults 6/5/14
// - Resolution option 10/6/8 bits, default 8
// - Digital input mask, default none masked
// - Channel two source: pin or quarter supply
// - Sensor power polarity invertible
// - Alert edges wake; edge choice gates telegram
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "wrs_cfg.svh"

module wrs_top #(
   parameter int unsigned SEC_CYCLES = `WRS_SEC_CYC,
   parameter int unsigned STEP_CYCLES = `WRS_STEP_CYC
) (
   input wire logic clk_i, // 250 MHz
   input wire logic rst_i, // Sync, active high
   input wire wrs_pkg::wrs_wb_req_t wb_req_i, // Wishbone request
   output logic wb_ack_o, // Wishbone ack
   output logic [31:0] wb_dat_o, // Wishbone read data
   input wire wrs_pkg::wrs_pins_t pins_i, // Asynchronous pins
   output logic ulp_enable_o, // Regulator, watchdog, alert enable
   output logic shutdown_o, // Shutdown in progress
   output logic charge_control_output_o, // Charge pin level
   output logic charge_control_output_oe_n_o, // Low while driven
   output logic wake_o, // Wake-up pulse
   output logic telegram_o, // Transmit request pulse
   output logic sensor_power_control_o, // Sensor supply switch
   output logic sample_o, // Sampling moment pulse
   output wrs_pkg::wrs_acfg_t acfg_o // Active analog settings
);
   import wrs_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Value in [lo, hi] from a random byte, no divider needed
   function automatic logic [7:0] pick(input logic [7:0] lo, input logic [7:0] hi,
                                       input logic [7:0] rnd);
      logic [8:0] span;
      logic [16:0] prod;
      span = {1'b0, hi} - {1'b0, lo} + 9'h001;
      prod = {8'h00, span} * {9'h000, rnd};
      return lo + prod[15:8];
   endfunction

   // Edge select: bit0 rising, bit1 falling
   function automatic logic edge_hit(input logic [1:0] es, input logic now, input logic was);
      return (es[0] & now & ~was) | (es[1] & ~now & was);
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int NP = $bits(wrs_pins_t);
   logic [NP-1:0] s1_q, s2_q, s3_q, pf_q;
   wrs_pins_t pin;
   assign pin = wrs_pins_t'(pf_q);

   always_ff @(posedge clk_i) begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NP; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            pf_q[i] <= s3_q[i];
         end
      end
   end

   // ----------------------------------------
   // Programmed configuration area
   // ----------------------------------------
   logic [31:0] ctrl_q;
   logic [15:0] wake_per_q;
   logic [7:0] rmin_q, rmax_q;
   logic [31:0] thr_q;
   logic [7:0] dly_q;

   wire wb_go = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
   wire wb_wr = wb_go & wb_req_i.we;
   wire hit_ctrl = wb_req_i.adr == `WRS_OFS_CTRL;
   wire hit_wake = wb_req_i.adr == `WRS_OFS_WAKE;
   wire hit_retx = wb_req_i.adr == `WRS_OFS_RETX;
   wire hit_thr = wb_req_i.adr == `WRS_OFS_THR;
   wire hit_dly = wb_req_i.adr == `WRS_OFS_DLY;
   wire hit_stat = wb_req_i.adr == `WRS_OFS_STAT;
   wire [31:0] wake_new = merge({16'h0000, wake_per_q}, wb_req_i.dat, wb_req_i.sel);
   wire [31:0] retx_new = merge({16'h0000, rmax_q, rmin_q}, wb_req_i.dat, wb_req_i.sel);
   wire [31:0] dly_new = merge({24'h000000, dly_q}, wb_req_i.dat, wb_req_i.sel);
   // Out-of-range periods are clamped so the timer always has a legal value
   wire [15:0] wake_clip = (wake_new[15:0] == 16'h0000) ? 16'h0001 :
                           (wake_new[15:0] > `WRS_WAKE_MAX) ? `WRS_WAKE_MAX : wake_new[15:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `WRS_CTRL_RST;
         wake_per_q <= `WRS_WAKE_RST;
         rmin_q <= `WRS_RETX_MIN_RST;
         rmax_q <= `WRS_RETX_MAX_RST;
         thr_q <= {`WRS_THR2_RST, 4'h0, `WRS_THR1_RST, 2'h0, `WRS_THR0_RST};
         dly_q <= `WRS_DLY_RST;
      end else if (wb_wr) begin
         if (hit_ctrl) ctrl_q <= merge(ctrl_q, wb_req_i.dat, wb_req_i.sel);
         if (hit_wake) wake_per_q <= wake_clip;
         if (hit_retx) begin
            rmin_q <= retx_new[7:0];
            // Max below min would wrap the span; hold max at min instead
            rmax_q <= (retx_new[15:8] < retx_new[7:0]) ? retx_new[7:0] : retx_new[15:8];
         end
         if (hit_thr) thr_q <= merge(thr_q, wb_req_i.dat, wb_req_i.sel);
         if (hit_dly) dly_q <= dly_new[7:0];
      end
   end

   // ----------------------------------------
   // Active configuration, loaded at reset only
   // ----------------------------------------
   logic load_q, xrst_q;
   logic [31:0] act_ctrl_q;
   logic [15:0] act_wake_q;
   logic [7:0] act_rmin_q, act_rmax_q, act_dly_q;
   wire ext_rst_rel = pin.ext_reset_n & ~xrst_q;
   wire do_load = load_q | ext_rst_rel;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_q <= 1'b1;
         xrst_q <= 1'b1;
         act_ctrl_q <= 32'h00000000;
         act_wake_q <= `WRS_WAKE_RST;
         act_rmin_q <= `WRS_RETX_MIN_RST;
         act_rmax_q <= `WRS_RETX_MAX_RST;
         act_dly_q <= `WRS_DLY_RST;
         acfg_o <= '0;
      end else begin
         load_q <= 1'b0;
         xrst_q <= pin.ext_reset_n;
         if (do_load) begin
            act_ctrl_q <= ctrl_q;
            act_wake_q <= wake_per_q;
            act_rmin_q <= rmin_q;
            act_rmax_q <= rmax_q;
            act_dly_q <= dly_q;
            acfg_o.res_opt <= ctrl_q[`WRS_CTRL_RES_OPT];
            acfg_o.ad2_int <= ctrl_q[`WRS_CTRL_AD2_INT];
            acfg_o.thr0 <= thr_q[`WRS_THR0_POS +: 10];
            acfg_o.thr1 <= thr_q[`WRS_THR1_POS +: 8];
            acfg_o.thr2 <= thr_q[`WRS_THR2_POS +: 8];
            acfg_o.di_mask <= ctrl_q[`WRS_CTRL_MASK +: 4];
         end
      end
   end

   // ----------------------------------------
   // Threshold detector and charge output
   // ----------------------------------------
   wrs_pwr_t pwr_q;
   logic started_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_q <= WRS_OFF;
         started_q <= 1'b0;
         ulp_enable_o <= 1'b0;
         shutdown_o <= 1'b0;
         charge_control_output_o <= 1'b0;
         charge_control_output_oe_n_o <= 1'b1;
      end else begin
         case (pwr_q)
            WRS_OFF: begin
               if (pin.above_on) pwr_q <= WRS_RUN;
            end
            WRS_RUN: begin
               if (pin.at_off) pwr_q <= WRS_SHDN;
            end
            WRS_SHDN: begin
               if (pin.above_on) pwr_q <= WRS_RUN;
            end
            default: pwr_q <= WRS_OFF;
         endcase
         ulp_enable_o <= pin.above_on | (pwr_q == WRS_RUN & ~pin.at_off);
         shutdown_o <= pin.at_off & (pwr_q != WRS_OFF);
         if (pin.above_on) started_q <= 1'b1;
         if (!pin.deep_sleep) begin
            if (started_q | pin.above_on) begin
               charge_control_output_oe_n_o <= 1'b0;
               charge_control_output_o <= pin.above_on & ~pin.at_off;
            end
         end
      end
   end

   // ----------------------------------------
   // Wake-up timer
   // ----------------------------------------
   logic [31:0] pre_q;
   logic [15:0] sec_q;
   logic [15:0] per_q;
   logic al0_q, al1_q;
   logic [1:0] pin_rtx_q;
   // Raw comparator too, so no wake leaves while the enable is dropping
   wire running = (pwr_q == WRS_RUN) & ~pin.at_off;
   wire tick = running & (pre_q == SEC_CYCLES - 1);
   wire timer_wake = tick & (per_q != 16'h0000) & (sec_q + 16'h0001 >= per_q);
   wire al0_chg = running & (pin.alert0 != al0_q);
   wire al1_chg = running & (pin.alert1 != al1_q);
   wire alert_wake = al0_chg | al1_chg;
   wire alert_tx = (al0_chg & edge_hit(act_ctrl_q[`WRS_CTRL_EDGE0 +: 2], pin.alert0, al0_q)) |
                   (al1_chg & edge_hit(act_ctrl_q[`WRS_CTRL_EDGE1 +: 2], pin.alert1, al1_q));
   wire any_wake = timer_wake | alert_wake;
   // Straps read 1 when open (pulled up), 0 when grounded
   wire [15:0] strap_per = ({pin.cyc1, pin.cyc0} == 2'b11) ? `WRS_PER_A :
                           ({pin.cyc1, pin.cyc0} == 2'b10) ? `WRS_PER_B :
                           ({pin.cyc1, pin.cyc0} == 2'b01) ? `WRS_PER_C : 16'h0000;
   // At a load the fresh settings win over the stale active copy
   wire [31:0] cfg_ctrl = do_load ? ctrl_q : act_ctrl_q;
   wire [15:0] cfg_wake = do_load ? wake_per_q : act_wake_q;
   wire [15:0] next_per = cfg_ctrl[`WRS_CTRL_WAKE_OVR] ? cfg_wake : strap_per;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= 32'h00000000;
         sec_q <= 16'h0000;
         per_q <= 16'h0000;
         al0_q <= 1'b0;
         al1_q <= 1'b0;
         pin_rtx_q <= 2'b00;
      end else begin
         al0_q <= pin.alert0;
         al1_q <= pin.alert1;
         pre_q <= (~running | tick) ? 32'h00000000 : pre_q + 32'h00000001;
         if (any_wake | do_load | ~running) begin
            sec_q <= 16'h0000;
            per_q <= next_per;
            pin_rtx_q <= {pin.rtx1, pin.rtx0};
         end else if (tick) begin
            sec_q <= sec_q + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Redundant retransmission counter
   // ----------------------------------------
   logic [15:0] lfsr_q;
   logic [7:0] rcnt_q;
   wire rtx_never = ~cfg_ctrl[`WRS_CTRL_RETX_OVR] & (pin_rtx_q == 2'b00);
   wire [7:0] lo = cfg_ctrl[`WRS_CTRL_RETX_OVR] ? (do_load ? rmin_q : act_rmin_q) :
                   (pin_rtx_q == 2'b10) ? `WRS_RTX_B_MIN :
                   (pin_rtx_q == 2'b01) ? `WRS_RTX_C_MIN : 8'h01;
   wire [7:0] hi = cfg_ctrl[`WRS_CTRL_RETX_OVR] ? (do_load ? rmax_q : act_rmax_q) :
                   (pin_rtx_q == 2'b10) ? `WRS_RTX_B_MAX :
                   (pin_rtx_q == 2'b01) ? `WRS_RTX_C_MAX : 8'h01;
   wire [7:0] reload = pick(lo, hi, lfsr_q[7:0]);
   wire rtx_fire = timer_wake & ~rtx_never & (rcnt_q <= 8'h01);
   wire tx = rtx_fire | alert_tx;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lfsr_q <= 16'hace1;
         rcnt_q <= 8'h01;
      end else begin
         // Keeps stepping in every state so reloads stay uncorrelated
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         if (tx | do_load) begin
            rcnt_q <= (reload == 8'h00) ? 8'h01 : reload;
         end else if (timer_wake & ~rtx_never) begin
            rcnt_q <= rcnt_q - 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Sensor power and sampling
   // ----------------------------------------
   logic sco_on_q;
   logic [31:0] stp_q;
   logic [7:0] nstep_q;
   wire step_end = stp_q == STEP_CYCLES - 1;
   wire dly_done = sco_on_q & (nstep_q == act_dly_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sco_on_q <= 1'b0;
         stp_q <= 32'h00000000;
         nstep_q <= 8'h00;
         wake_o <= 1'b0;
         telegram_o <= 1'b0;
         sample_o <= 1'b0;
         sensor_power_control_o <= 1'b0;
      end else begin
         wake_o <= any_wake;
         telegram_o <= tx;
         sample_o <= dly_done & ~any_wake;
         if (any_wake) begin
            // A new wake restarts the delay rather than stacking samples
            sco_on_q <= 1'b1;
            stp_q <= 32'h00000000;
            nstep_q <= 8'h00;
         end else if (dly_done) begin
            sco_on_q <= 1'b0;
         end else if (sco_on_q) begin
            stp_q <= step_end ? 32'h00000000 : stp_q + 32'h00000001;
            if (step_end) nstep_q <= nstep_q + 8'h01;
         end
         sensor_power_control_o <= (sco_on_q & ~dly_done) ^ act_ctrl_q[`WRS_CTRL_SCO_INV];
      end
   end

   // ----------------------------------------
   // Wishbone read and acknowledge
   // ----------------------------------------
   wire [31:0] stat = {8'h00, rcnt_q, 8'h00, 3'b000, started_q, pwr_q, pin.at_off, pin.above_on};
   wire [31:0] rd = hit_ctrl ? ctrl_q :
                    hit_wake ? {16'h0000, wake_per_q} :
                    hit_retx ? {16'h0000, rmax_q, rmin_q} :
                    hit_thr ? thr_q :
                    hit_dly ? {24'h000000, dly_q} :
                    hit_stat ? stat : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_go;
         wb_dat_o <= wb_go ? rd : 32'h00000000;
      end
   end

endmodule // wrs_top

`default_nettype wire

// ### design/wrs_cfg.svh
`ifndef WRS_CFG_SVH
`define WRS_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WRS_OFS_CTRL 8'h00
`define WRS_OFS_WAKE 8'h04
`define WRS_OFS_RETX 8'h08
`define WRS_OFS_THR 8'h0c
`define WRS_OFS_DLY 8'h10
`define WRS_OFS_STAT 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WRS_CTRL_WAKE_OVR 0
`define WRS_CTRL_RETX_OVR 1
`define WRS_CTRL_RES_OPT 2
`define WRS_CTRL_AD2_INT 3
`define WRS_CTRL_SCO_INV 4
`define WRS_CTRL_EDGE0 8
`define WRS_CTRL_EDGE1 10
`define WRS_CTRL_MASK 16
`define WRS_THR0_POS 0
`define WRS_THR1_POS 12
`define WRS_THR2_POS 24

// ----------------------------------------
// Reset values and wake period clamp
// ----------------------------------------
`define WRS_CTRL_RST 32'h00000f00
`define WRS_WAKE_RST 16'h0001
`define WRS_RETX_MIN_RST 8'h01
`define WRS_RETX_MAX_RST 8'h01
`define WRS_THR0_RST 10'h006
`define WRS_THR1_RST 8'h05
`define WRS_THR2_RST 8'h0e
`define WRS_DLY_RST 8'h01
`define WRS_WAKE_MAX 16'hfffe

// ----------------------------------------
// Strap-selected periods and intervals
// ----------------------------------------
`define WRS_PER_A 16'h0001
`define WRS_PER_B 16'h000a
`define WRS_PER_C 16'h0064
`define WRS_RTX_B_MIN 8'h07
`define WRS_RTX_B_MAX 8'h0e
`define WRS_RTX_C_MIN 8'h46
`define WRS_RTX_C_MAX 8'h8c

// ----------------------------------------
// Timing
// ----------------------------------------
`define WRS_CLK_HZ 250000000
`define WRS_TICK_S 1
`define WRS_STEP_MS 2
`define WRS_SEC_CYC (`WRS_TICK_S * `WRS_CLK_HZ)
`define WRS_STEP_CYC (`WRS_STEP_MS * (`WRS_CLK_HZ / 1000))

`endif

// ### design/wrs_pkg.sv
package wrs_pkg;

   typedef enum logic [1:0] {
      WRS_OFF = 2'b00,
      WRS_RUN = 2'b01,
      WRS_SHDN = 2'b11
   } wrs_pwr_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wrs_wb_req_t;

   typedef struct packed {
      logic res_opt;
      logic ad2_int;
      logic [9:0] thr0;
      logic [7:0] thr1;
      logic [7:0] thr2;
      logic [3:0] di_mask;
   } wrs_acfg_t;

   typedef struct packed {
      logic above_on;
      logic at_off;
      logic deep_sleep;
      logic ext_reset_n;
      logic alert0;
      logic alert1;
      logic cyc0;
      logic cyc1;
      logic rtx0;
      logic rtx1;
   } wrs_pins_t;

endpackage

// ### verif/wrs_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wrs_top_chk #(
   parameter int unsigned SEC_CYCLES = 20,
   parameter int unsigned STEP_CYCLES = 4
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire wrs_pkg::wrs_wb_req_t wb_req_i, // Bus request
   input wire logic wb_ack_o, // Bus ack
   input wire logic [31:0] wb_dat_o, // Read data
   input wire wrs_pkg::wrs_pins_t pins_i, // Pins
   input wire logic ulp_enable_o, // Enable
   input wire logic charge_control_output_o, // Charge level
   input wire logic charge_control_output_oe_n_o, // Charge float
   input wire logic wake_o, // Wake pulse
   input wire logic telegram_o, // Send pulse
   input wire wrs_pkg::wrs_acfg_t acfg_o // Analog config
);
   import wrs_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------
   // Sequences
   // ----------------
   sequence s_take; wb_req_i.cyc && wb_req_i.stb && !wb_ack_o; endsequence
   sequence s_off; (pins_i.at_off && !pins_i.deep_sleep) [*8]; endsequence
   sequence s_sleep; pins_i.deep_sleep [*8]; endsequence
   // Filter latency needs a margin past the rising edge
   sequence s_quiet; pins_i.ext_reset_n [*8] ##1 pins_i.ext_reset_n; endsequence
   // ----------------
   // Properties
   // ----------------
   property p_ack_next; s_take |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_wake_run; wake_o |-> ulp_enable_o; endproperty
   property p_tel_wake; telegram_o |-> wake_o; endproperty
   property p_drive_high;
      $fell(charge_control_output_oe_n_o) |-> charge_control_output_o;
   endproperty
   property p_off_low; s_off |-> !charge_control_output_o; endproperty
   property p_sleep_hold;
      s_sleep |-> $stable(charge_control_output_o) && $stable(charge_control_output_oe_n_o);
   endproperty
   property p_cfg_hold; s_quiet |-> $stable(acfg_o); endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
   a_wake_run: assert property (p_wake_run) else $error("wake while disabled");
   a_tel_wake: assert property (p_tel_wake) else $error("send without wake");
   a_drive_high: assert property (p_drive_high) else $error("drive start low");
   a_off_low: assert property (p_off_low) else $error("charge high below off");
   a_sleep_hold: assert property (p_sleep_hold) else $error("charge moved in sleep");
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed w/o reset");
endmodule // wrs_top_chk
bind wrs_top wrs_top_chk #(.SEC_CYCLES(SEC_CYCLES), .STEP_CYCLES(STEP_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .pins_i(pins_i), .ulp_enable_o(ulp_enable_o),
   .charge_control_output_o(charge_control_output_o),
   .charge_control_output_oe_n_o(charge_control_output_oe_n_o),
   .wake_o(wake_o), .telegram_o(telegram_o), .acfg_o(acfg_o));
`default_nettype wire

// ### verif/wrs_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
// Radio side: counts requests and wakes between sends
module wrs_radio_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic wake_i, // Wake pulse
   input wire logic telegram_i, // Send pulse
   output var int n_wake_o, // Wakes seen
   output var int n_tel_o, // Sends seen
   output var int last_gap_o // Wakes per send
);
   int since;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         n_wake_o <= 0;
         n_tel_o <= 0;
         last_gap_o <= 0;
         since <= 0;
      end else begin
         if (wake_i) n_wake_o <= n_wake_o + 1;
         if (telegram_i) begin
            n_tel_o <= n_tel_o + 1;
            last_gap_o <= since + int'(wake_i);
            since <= 0;
         end else if (wake_i) since <= since + 1;
      end
   end
endmodule // wrs_radio_model
`default_nettype wire

// ### verif/wrs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wrs_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module wrs_top_tb;
   import wrs_pkg::*;
   localparam int S = 20;
   localparam int P = 4;
   localparam wrs_acfg_t DEF = {2'b00, 10'h006, 8'h05, 8'h0e, 4'h0};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wrs_wb_req_t req = '0;
   wrs_pins_t pins = wrs_pins_t'(10'h04f);
   wrs_acfg_t acfg;
   logic ack, ulp, shdn, charge_control_output, cco_oe_n, wake, tel, spc, smp;
   logic [31:0] rdat, q;
   logic [9:0] t0;
   logic [7:0] t1, t2, dly;
   int err_total = 0, total_checks = 0, cyc = 0, nw, nt, lg, n, k, a;
   logic [1:0] sv[4] = '{2'b11, 2'b01, 2'b10, 2'b00};
   int per[4] = '{1, 10, 100, 0};
   logic [1:0] rv[3] = '{2'b11, 2'b01, 2'b10};
   int lo[3] = '{1, 7, 70};
   int hi[3] = '{1, 14, 140};
   always #2 clk_i = ~clk_i;
   wrs_top #(.SEC_CYCLES(S), .STEP_CYCLES(P)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .pins_i(pins), .ulp_enable_o(ulp),
      .shutdown_o(shdn), .charge_control_output_o(charge_control_output), .charge_control_output_oe_n_o(cco_oe_n),
      .wake_o(wake), .telegram_o(tel), .sensor_power_control_o(spc), .sample_o(smp),
      .acfg_o(acfg));
   wrs_radio_model u_radio (.clk_i(clk_i), .rst_i(rst_i), .wake_i(wake), .telegram_i(tel),
      .n_wake_o(nw), .n_tel_o(nt), .last_gap_o(lg));
   // ----------------
   // Tasks
   // ----------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int m;
      m = 0;
      @(posedge clk_i);
      req <= {2'b11, w, ad, 4'hf, d};
      do begin
         @(posedge clk_i);
         m++;
      end while (ack !== 1'b1 && m < 40);
      `CHK(ack, 1'b1)
      q = rdat;
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      wb(1'b0, ad, 32'h0);
      `CHK(q, e)
   endtask
   task automatic gap(input int lim);
      n = 0;
      do begin @(negedge clk_i); n++; end while (wake !== 1'b1 && n < lim);
   endtask
   task automatic waitel();
      int t;
      t = nt;
      k = 0;
      while (nt == t && k++ < 3000) @(negedge clk_i);
      `CHK(k <= 3000, 1'b1)
   endtask
   task automatic alert(input int pin, input logic v, input int e);
      int w0, e0;
      w0 = nw;
      e0 = nt;
      @(posedge clk_i);
      if (pin == 0) pins.alert0 <= v;
      else pins.alert1 <= v;
      tick(10);
      @(negedge clk_i);
      `CHK(nw - w0, 1)
      `CHK(nt - e0, e)
   endtask
   // Slow overflow guard; whole run stays under 20k cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin err_total++; test_done(); end
   end
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      void'($urandom(32'h2aa1));
      tick(4);
      rst_i <= 1'b0;
      tick(10);
      @(negedge clk_i);
      `CHK(cco_oe_n, 1'b1)
      `CHK(acfg, DEF)
      rd(`WRS_OFS_CTRL, 32'h00000f00);
      rd(`WRS_OFS_WAKE, 32'h1);
      rd(`WRS_OFS_RETX, 32'h0101);
      rd(`WRS_OFS_THR, 32'h0e005006);
      rd(`WRS_OFS_DLY, 32'h1);
      wb(1'b1, 8'h20, 32'hffffffff);
      rd(8'h20, 32'h0);
      pins.above_on <= 1'b1;
      tick(10);
      @(negedge clk_i);
      `CHK({cco_oe_n, charge_control_output, ulp}, 3'b011)
      @(posedge clk_i);
      pins.above_on <= 1'b0;
      tick(10);
      @(negedge clk_i);
      `CHK(charge_control_output, 1'b0)
      @(posedge clk_i);
      pins.above_on <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         {pins.cyc0, pins.cyc1} <= sv[i];
         // Let the filter settle so the next wake latches the new period
         tick(8);
         gap(2500);
         gap(2500);
         if (per[i] == 0) `CHK(n, 2500)
         else `CHK(n * 5 >= per[i] * S * 4 && n * 5 <= per[i] * S * 6, 1'b1)
      end
      // With no cyclic wake nothing resamples the straps; a reset reload does
      @(posedge clk_i);
      {pins.cyc0, pins.cyc1, pins.ext_reset_n} <= 3'b110;
      tick(6);
      pins.ext_reset_n <= 1'b1;
      tick(12);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         {pins.cyc0, pins.cyc1, pins.rtx0, pins.rtx1} <= {2'b11, rv[i]};
         tick(8);
         repeat (2) waitel();
         repeat (2) begin
            waitel();
            `CHK(lg >= lo[i] && lg <= hi[i], 1'b1)
         end
      end
      @(posedge clk_i);
      {pins.rtx0, pins.rtx1} <= 2'b00;
      tick(100);
      a = nt;
      k = nw;
      tick(600);
      `CHK(nt - a, 0)
      `CHK(nw - k >= 25, 1'b1)
      {pins.cyc0, pins.cyc1} <= 2'b00;
      tick(100);
      t0 = 10'($urandom);
      t1 = 8'($urandom);
      t2 = 8'($urandom);
      dly = 8'($urandom_range(8, 1));
      wb(1'b1, `WRS_OFS_CTRL, 32'h000a0d1f);
      wb(1'b1, `WRS_OFS_WAKE, 32'h3);
      wb(1'b1, `WRS_OFS_RETX, 32'h0202);
      wb(1'b1, `WRS_OFS_THR, {t2, 4'h0, t1, 2'h0, t0});
      wb(1'b1, `WRS_OFS_DLY, {24'h0, dly});
      rd(`WRS_OFS_CTRL, 32'h000a0d1f);
      `CHK(acfg, DEF)
      alert(0, 1'b1, 1);
      alert(0, 1'b0, 1);
      `CHK(spc, 1'b0)
      @(posedge clk_i);
      pins.ext_reset_n <= 1'b0;
      tick(6);
      pins.ext_reset_n <= 1'b1;
      tick(12);
      @(negedge clk_i);
      `CHK(acfg, {2'b11, t0, t1, t2, 4'ha})
      gap(200);
      gap(200);
      `CHK(n * 5 >= 3 * S * 4 && n * 5 <= 3 * S * 6, 1'b1)
      @(negedge clk_i);
      `CHK(spc, 1'b0)
      k = 1;
      while (smp !== 1'b1 && k < 100) begin @(negedge clk_i); k++; end
      `CHK(k >= dly * P - 1 && k <= dly * P + 1, 1'b1)
      tick(2);
      @(negedge clk_i);
      `CHK(spc, 1'b1)
      repeat (2) waitel();
      a = lg;
      waitel();
      `CHK(lg, a)
      `CHK(a, 2)
      gap(200);
      tick(2);
      alert(0, 1'b1, 1);
      alert(0, 1'b0, 0);
      gap(200);
      tick(2);
      alert(1, 1'b1, 1);
      alert(1, 1'b0, 1);
      @(posedge clk_i);
      pins.deep_sleep <= 1'b1;
      tick(8);
      pins.above_on <= 1'b0;
      tick(10);
      @(negedge clk_i);
      `CHK(charge_control_output, 1'b1)
      @(posedge clk_i);
      pins.deep_sleep <= 1'b0;
      pins.at_off <= 1'b1;
      tick(12);
      @(negedge clk_i);
      `CHK({shdn, charge_control_output}, 2'b10)
      test_done();
   end
endmodule // wrs_top_tb
`default_nettype wire
